/* File: hdl/pcsia_core.sv */
// Program counter, circular return stack and indirect data address path.
`timescale 1ns/1ps
`default_nettype none
module pcsia_core
    import pcsia_pkg::*;
#(
    parameter int unsigned STACK_DEPTH = PCSIA_DEPTH  // Return stack entries, a power of two.
)
(
    input  wire logic        clk_i,        // Core clock, 200 MHz.
    input  wire logic        nrst_i,       // Asynchronous reset, active low.
    input  wire pcsia_op_t   op_i,         // Sequencer action this cycle.
    input  wire logic [10:0] br_target_i,  // Branch target from instruction word.
    input  wire logic [12:0] vector_i,     // Interrupt vector address.
    input  wire logic        pcl_wr_i,     // Low byte written (direct or ALU result).
    input  wire logic [7:0]  pcl_wdata_i,  // Byte written to low byte.
    input  wire logic        latch_wr_i,   // pc_high_latch write strobe.
    input  wire logic [7:0]  latch_wdata_i,// pc_high_latch write data.
    input  wire logic [7:0]  ptr_i,        // Current indirect_pointer value.
    input  wire logic        bank_i,       // indirect_bank_bit, status bit 7.
    input  wire pcsia_dreq_t dreq_i,       // Data access request.
    output logic [12:0]      pc_o,         // Program counter, fetch address.
    output logic [7:0]       pcl_rdata_o,  // Readable low byte.
    output logic [7:0]       latch_o,      // pc_high_latch contents.
    output logic [8:0]       daddr_o,      // Effective data address.
    output logic             dwr_o,        // Data write strobe to register file.
    output logic [7:0]       dwdata_o,     // Data write value.
    output logic             rd_zero_o     // Read data forced to zero.
);
    ////////////////////////////////////////////////////////////////////////
    // The pointer width follows the depth. The depth must be a power of two,
    // or the pointer would not wrap onto the oldest entry after a full round.
    localparam int unsigned SP_W = $clog2(STACK_DEPTH);

    typedef logic [SP_W-1:0] pcsia_sp_t;

    logic [12:0] pc_q;
    logic [12:0] pc_d;
    logic [12:0] pc_inc;
    logic [12:0] branch_pc;
    logic [12:0] low_pc;

    logic [7:0]  latch_q;
    logic [7:0]  latch_d;

    pcsia_sp_t   sp_q;
    pcsia_sp_t   sp_d;
    pcsia_sp_t   sp_prev;
    logic [12:0] stack_q [STACK_DEPTH];
    logic [12:0] stack_d [STACK_DEPTH];
    logic        push;
    logic        pop;
    logic [12:0] push_val;
    logic [12:0] top_val;

    logic        self_sel;
    logic [8:0]  daddr_q;
    logic [8:0]  daddr_d;
    logic        dwr_q;
    logic        dwr_d;
    logic [7:0]  dwdata_q;
    logic [7:0]  dwdata_d;
    logic        rdz_q;
    logic        rdz_d;

    ////////////////////////////////////////////////////////////////////////
    // The pointer wraps silently in both directions. Software cannot see an
    // overflow or underflow, so a lost return address goes unnoticed.
    function automatic pcsia_sp_t sp_step(
        input pcsia_sp_t sp,
        input logic      up
    );
        pcsia_sp_t nxt;
        if (up) begin
            nxt = SP_W'(sp + 1'b1);
        end else begin
            nxt = SP_W'(sp - 1'b1);
        end
        return nxt;
    endfunction

    // A branch keeps the page chosen in latch bits 4:3.
    function automatic logic [12:0] branch_addr(
        input logic [7:0]  latch,
        input logic [10:0] target
    );
        return {latch[4:3], target};
    endfunction

    // A low-byte load takes all five page bits from the latch.
    function automatic logic [12:0] low_load_addr(
        input logic [7:0] latch,
        input logic [7:0] low
    );
        return {latch[4:0], low};
    endfunction

    function automatic logic is_push(
        input pcsia_op_t op
    );
        return (op == PCSIA_OP_CALL) || (op == PCSIA_OP_VEC);
    endfunction

    function automatic logic is_pop(
        input pcsia_op_t op
    );
        return op == PCSIA_OP_RET;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        push     = is_push(op_i);
        pop      = is_pop(op_i);
        sp_prev  = sp_step(sp_q, 1'b0);
        top_val  = stack_q[sp_prev];
        // An interrupt resumes the interrupted instruction, so its own address
        // is saved; a call saves the address that follows it.
        if (op_i == PCSIA_OP_VEC) begin
            push_val = pc_q;
        end else begin
            push_val = pc_inc;
        end
        sp_d = sp_q;
        for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_d[i] = stack_q[i];
        end
        if (push) begin
            stack_d[sp_q] = push_val;
            sp_d          = sp_step(sp_q, 1'b1);
        end else if (pop) begin
            sp_d = sp_prev;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sp_q <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_q[i] <= PCSIA_PC_RST;
            end
        end else begin
            sp_q <= sp_d;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_q[i] <= stack_d[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        latch_d = latch_q;
        if (latch_wr_i) begin
            latch_d = latch_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            latch_q <= PCSIA_LATCH_RST;
        end else begin
            latch_q <= latch_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        pc_inc    = 13'(pc_q + PCSIA_PC_ONE);
        branch_pc = branch_addr(latch_q, br_target_i);
        low_pc    = low_load_addr(latch_q, pcl_wdata_i);
        pc_d      = pc_q;
        case (op_i)
            PCSIA_OP_SEQ: begin
                pc_d = pc_inc;
            end
            PCSIA_OP_CALL: begin
                pc_d = branch_pc;
            end
            PCSIA_OP_JUMP: begin
                pc_d = branch_pc;
            end
            PCSIA_OP_RET: begin
                pc_d = top_val;
            end
            PCSIA_OP_VEC: begin
                pc_d = vector_i;
            end
            PCSIA_OP_HOLD: begin
                pc_d = pc_q;
            end
            default: begin
                pc_d = pc_q;
            end
        endcase
        // A low-byte write wins over sequencing, so a computed branch through
        // an arithmetic result behaves exactly like a direct write.
        if (pcl_wr_i) begin
            pc_d = low_pc;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pc_q <= PCSIA_PC_RST;
        end else begin
            pc_q <= pc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        self_sel = dreq_i.ind && (ptr_i == PCSIA_IND_PORT);
        if (dreq_i.ind) begin
            daddr_d = {bank_i, ptr_i};
        end else begin
            daddr_d = dreq_i.daddr;
        end
        rdz_d    = self_sel;
        dwr_d    = dreq_i.wr && !self_sel;
        dwdata_d = dreq_i.wdata;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            daddr_q  <= 9'h000;
            dwr_q    <= 1'b0;
            dwdata_q <= 8'h00;
            rdz_q    <= 1'b0;
        end else begin
            daddr_q  <= daddr_d;
            dwr_q    <= dwr_d;
            dwdata_q <= dwdata_d;
            rdz_q    <= rdz_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Only the low byte is exposed; the page bits stay hidden from reads.
    assign pc_o        = pc_q;
    assign pcl_rdata_o = pc_q[7:0];
    assign latch_o     = latch_q;
    assign daddr_o     = daddr_q;
    assign dwr_o       = dwr_q;
    assign dwdata_o    = dwdata_q;
    assign rd_zero_o   = rdz_q;
endmodule
`default_nettype wire

/* File: hdl/pcsia_pkg.sv */
// Package of constants and types for the program counter, return stack and indirect path.
// Operation
// - Keep a 13-bit counter whose low byte is a readable, writable register.
// - Upper five counter bits are unreadable and load only through pc_high_latch.
// - Any reset clears the upper counter bits to zero.
// - Low-byte write loads byte into 7:0 and latch 4:0 into 12:8.
// - Branches take 11 instruction bits; latch bits 4:3 supply counter 12:11.
// - Eight-entry 13-bit return stack with a hidden stack pointer.
// - Push the counter on subroutine branch or interrupt vectoring.
// - Any of three exits pops and restores all 13 counter bits; the code has one exit only, PCSIA_OP_RET.
// - Pushes and pops leave pc_high_latch unchanged.
// - Stack is circular; the ninth push overwrites the first entry.
// - No status indication on stack overflow or underflow.
// - Accesses to indirect_data_port go to the register that indirect_pointer selects.
// - Indirect read selecting indirect_data_port itself returns zero.
// - Indirect write selecting indirect_data_port itself changes no register.
// - Indirect address is indirect_bank_bit above the 8-bit indirect_pointer.
package pcsia_pkg;
    localparam int          PCSIA_PC_W      = 13;
    localparam int          PCSIA_DEPTH     = 8;
    localparam int          PCSIA_SP_W      = 3;
    localparam int          PCSIA_BR_W      = 11;
    localparam int          PCSIA_DADDR_W   = 9;
    localparam logic [12:0] PCSIA_PC_RST    = 13'h0000;
    localparam logic [7:0]  PCSIA_LATCH_RST = 8'h00;
    localparam logic [7:0]  PCSIA_IND_PORT  = 8'h00;
    localparam logic [12:0] PCSIA_PC_ONE    = 13'h0001;

    typedef enum logic [2:0] {
        PCSIA_OP_SEQ  = 3'h0,
        PCSIA_OP_CALL = 3'h1,
        PCSIA_OP_JUMP = 3'h3,
        PCSIA_OP_RET  = 3'h2,
        PCSIA_OP_VEC  = 3'h6,
        PCSIA_OP_HOLD = 3'h7
    } pcsia_op_t;

    typedef struct packed {
        logic        ind;      // Operand addresses indirect_data_port.
        logic [8:0]  daddr;    // Direct data address.
        logic        wr;       // Data write strobe.
        logic [7:0]  wdata;    // Write data.
    } pcsia_dreq_t;
endpackage

/* File: sim/pcsia_rf_model.sv */
// Register file model behind the indirect data path.
`timescale 1ns/1ps
`default_nettype none
module pcsia_rf_model (
    input  wire logic       clk_i,     // Clock.
    input  wire logic [8:0] daddr_i,   // Address.
    input  wire logic       dwr_i,     // Write.
    input  wire logic [7:0] dwdata_i,  // Data.
    input  wire logic       rd_zero_i, // Zero read.
    output logic      [7:0] rdata_o    // Read data.
);
    logic [7:0] mem_q [512] = '{default: 8'h00};
    assign rdata_o = rd_zero_i ? 8'h00 : mem_q[daddr_i];
    always @(posedge clk_i) if (dwr_i) mem_q[daddr_i] <= dwdata_i;
endmodule
`default_nettype wire

/* File: sim/pcsia_core_sva.sv */
// Port checks for the counter, return stack and indirect path.
`timescale 1ns/1ps
`default_nettype none
module pcsia_core_sva
    import pcsia_pkg::*;
(
    input wire logic        clk_i,       // Clock.
    input wire logic        nrst_i,      // Reset.
    input wire pcsia_op_t   op_i,        // Action.
    input wire logic [10:0] br_target_i, // Target.
    input wire logic        pcl_wr_i,    // Low write.
    input wire logic [7:0]  pcl_wdata_i, // Low byte.
    input wire logic        latch_wr_i,  // Latch write.
    input wire logic [7:0]  ptr_i,       // Pointer.
    input wire logic        bank_i,      // Bank.
    input wire pcsia_dreq_t dreq_i,      // Request.
    input wire logic [12:0] pc_o,        // Counter.
    input wire logic [7:0]  latch_o,     // Latch.
    input wire logic [8:0]  daddr_o,     // Address.
    input wire logic        dwr_o,       // Write.
    input wire logic        rd_zero_o    // Zero read.
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    sequence s_call_ret;
        (op_i == PCSIA_OP_CALL && !pcl_wr_i) ##1 (op_i == PCSIA_OP_RET && !pcl_wr_i);
    endsequence
    reset_clear_a: assert property ($rose(nrst_i) |-> pc_o == 13'h0000)
        else $error("reset");
    low_load_a: assert property (pcl_wr_i |=> pc_o == {$past(latch_o[4:0]), $past(pcl_wdata_i)})
        else $error("low");
    branch_page_a: assert property (!pcl_wr_i && op_i inside {PCSIA_OP_CALL, PCSIA_OP_JUMP}
        |=> pc_o == {$past(latch_o[4:3]), $past(br_target_i)}) else $error("branch");
    seq_inc_a: assert property (!pcl_wr_i && op_i == PCSIA_OP_SEQ
        |=> pc_o == $past(pc_o) + 13'h0001) else $error("inc");
    call_ret_a: assert property (s_call_ret |=> pc_o == $past(pc_o, 2) + 13'h0001)
        else $error("return");
    latch_keep_a: assert property (!latch_wr_i && op_i inside {PCSIA_OP_CALL, PCSIA_OP_RET, PCSIA_OP_VEC}
        |=> $stable(latch_o)) else $error("latch");
    ind_addr_a: assert property (dreq_i.ind |=> daddr_o == {$past(bank_i), $past(ptr_i)})
        else $error("addr");
    self_ind_a: assert property (dreq_i.ind && ptr_i == PCSIA_IND_PORT |=> !dwr_o && rd_zero_o)
        else $error("self");
endmodule
bind pcsia_core pcsia_core_sva pcsia_core_sva_i (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .op_i        (op_i),
    .br_target_i (br_target_i),
    .pcl_wr_i    (pcl_wr_i),
    .pcl_wdata_i (pcl_wdata_i),
    .latch_wr_i  (latch_wr_i),
    .ptr_i       (ptr_i),
    .bank_i      (bank_i),
    .dreq_i      (dreq_i),
    .pc_o        (pc_o),
    .latch_o     (latch_o),
    .daddr_o     (daddr_o),
    .dwr_o       (dwr_o),
    .rd_zero_o   (rd_zero_o)
);
`default_nettype wire

/* File: sim/pcsia_core_tb.sv */
// Random bench with a reference model of counter, stack and data path.
`timescale 1ns/1ps
`default_nettype none
module pcsia_core_tb;
    import pcsia_pkg::*;
    logic clk_i = '0, nrst_i = '0, pcl_wr_i = '0, latch_wr_i = '0, bank_i = '0, dwr_o, rd_zero_o, z;
    logic [7:0] pcl_wdata_i = '0, latch_wdata_i = '0, ptr_i = '0, pcl_rdata_o, latch_o, dwdata_o, lat, rd;
    logic [12:0] vector_i = '0, pc_o, pc, stk [8];
    logic [10:0] br_target_i = '0;
    logic [8:0] daddr_o;
    logic [2:0] sp;
    logic [47:0] exp_q [$];
    logic [7:0] shd [512];
    pcsia_op_t op_i = PCSIA_OP_HOLD, o;
    pcsia_op_t ops [6] = '{PCSIA_OP_SEQ, PCSIA_OP_CALL, PCSIA_OP_JUMP, PCSIA_OP_RET, PCSIA_OP_VEC, PCSIA_OP_HOLD};
    pcsia_dreq_t dreq_i = '0;
    int err_total = 0, samples_checked = 0, seed = 33780, r;
    pcsia_core pcsia_core_i (
        .clk_i         (clk_i),
        .nrst_i        (nrst_i),
        .op_i          (op_i),
        .br_target_i   (br_target_i),
        .vector_i      (vector_i),
        .pcl_wr_i      (pcl_wr_i),
        .pcl_wdata_i   (pcl_wdata_i),
        .latch_wr_i    (latch_wr_i),
        .latch_wdata_i (latch_wdata_i),
        .ptr_i         (ptr_i),
        .bank_i        (bank_i),
        .dreq_i        (dreq_i),
        .pc_o          (pc_o),
        .pcl_rdata_o   (pcl_rdata_o),
        .latch_o       (latch_o),
        .daddr_o       (daddr_o),
        .dwr_o         (dwr_o),
        .dwdata_o      (dwdata_o),
        .rd_zero_o     (rd_zero_o)
    );
    pcsia_rf_model pcsia_rf_model_i (.clk_i(clk_i), .daddr_i(daddr_o), .dwr_i(dwr_o),
        .dwdata_i(dwdata_o), .rd_zero_i(rd_zero_o), .rdata_o(rd));
    always #2.5 clk_i = ~clk_i;
    task automatic step(pcsia_op_t op, logic pw, logic [7:0] pb, logic lw, logic [7:0] lb);
        logic [8:0] a;
        @(negedge clk_i);
        op_i = op;
        {pcl_wr_i, pcl_wdata_i, latch_wr_i, latch_wdata_i} = {pw, pb, lw, lb};
        {br_target_i, vector_i, dreq_i, bank_i, ptr_i} = 52'({$random(seed), $random(seed)});
        if (ptr_i[7:6] == 2'h0) ptr_i = PCSIA_IND_PORT;
        if (op inside {PCSIA_OP_CALL, PCSIA_OP_VEC}) stk[sp++] = pc + 13'(op == PCSIA_OP_CALL);
        if (op == PCSIA_OP_RET) pc = stk[--sp];
        if (op == PCSIA_OP_SEQ) pc = pc + 13'h0001;
        if (op inside {PCSIA_OP_CALL, PCSIA_OP_JUMP}) pc = {lat[4:3], br_target_i};
        if (op == PCSIA_OP_VEC) pc = vector_i;
        if (pw) pc = {lat[4:0], pb};
        if (lw) lat = lb;
        z = dreq_i.ind && ptr_i == PCSIA_IND_PORT;
        a = dreq_i.ind ? {bank_i, ptr_i} : dreq_i.daddr;
        exp_q.push_back({pc, lat, a, dreq_i.wr && !z, dreq_i.wdata, z, z ? 8'h00 : shd[a]});
        if (dreq_i.wr && !z) shd[a] = dreq_i.wdata;
    endtask
    task automatic bad(string m);
        err_total++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic chk(logic [47:0] e);
        samples_checked++;
        if ({pc_o, latch_o, daddr_o, dwr_o, dwdata_o, rd_zero_o} !== e[47:8]) bad("outputs");
        if (pcl_rdata_o !== e[42:35]) bad("low byte read");
        if (rd !== e[7:0]) bad("read data");
    endtask
    task final_report;
        if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_i) #1 if (exp_q.size() > 0) chk(exp_q.pop_front());
    initial begin
        repeat (8000) @(posedge clk_i);
        err_total++;
        final_report();
    end
    initial begin
        foreach (shd[i]) shd[i] = 8'h00;
        repeat (2) begin
            foreach (stk[i]) stk[i] = '0;
            {pc, lat, sp} = '0;
            repeat (12) @(posedge clk_i);
            @(negedge clk_i) nrst_i = 1'b1;
            step(PCSIA_OP_HOLD, 1'b0, 8'h00, 1'b1, 8'h18);
            repeat (9) step(PCSIA_OP_CALL, 1'b0, 8'h00, 1'b0, 8'h00);
            repeat (9) step(PCSIA_OP_RET, 1'b0, 8'h00, 1'b0, 8'h00);
            step(PCSIA_OP_RET, 1'b0, 8'h00, 1'b0, 8'h00);
            step(PCSIA_OP_HOLD, 1'b1, 8'hFF, 1'b1, 8'h0E);
            step(PCSIA_OP_SEQ, 1'b0, 8'h00, 1'b0, 8'h00);
            repeat (1500) begin
                r = $random(seed);
                o = ops[r[10:8] % 3'h6];
                step(o, r[1:0] == 2'h3 && o != PCSIA_OP_RET, r[23:16], r[3:2] == 2'h3,
                    r[31:24]);
            end
            // Idle one edge so the last queued write lands before reset is taken.
            @(negedge clk_i);
            op_i = PCSIA_OP_HOLD;
            {pcl_wr_i, latch_wr_i, dreq_i} = '0;
            @(negedge clk_i) nrst_i = 1'b0;
        end
        final_report();
    end
endmodule
`default_nettype wire
